// [vic_top.sv]
// Contract
// R1 - eleven sources: three external, seven internal, break
// R2 - accept needs enable, request, clear disable flag
// R3 - software clears request bits, never sets them
// R4 - enable bits freely readable and writable
// R5 - select bits 7,6,5 pick shared sources
// R6 - reset and break unmaskable; others gated
// R7 - fixed priority, reset first, break last
// R8 - fixed vector pair per priority level
// R9 - acceptance sets disable flag, clears request
// R10 - software disables before changing active edge
// R11 - external pin edge polarity software selected
// R12 - key request on falling AND of inputs
// R13 - only input-configured key pins take part
// R14 - slots 2,3 carry UART or USB by mode
// R15 - shared slots 5,7,8 arrangement
// R16 - timer 1 underflow raises priority 6
// R17 - request latched until cleared or accepted
`timescale 1ns/1ps
`default_nettype none
module vic_top
(
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output var  logic [31:0]           avs_readdata,
   output var  logic                  avs_waitrequest,
   input  wire vic_pkg::vic_src_s     src,
   input  wire logic                  ext_irq_pin,
   input  wire logic                  timer_x_io_pin,
   input  wire logic [7:0]            key_input_port,
   input  wire logic [7:0]            key_port_dir,
   input  wire vic_pkg::vic_core_in_s core_in,
   output var  vic_pkg::vic_core_out_s core_out,
   output var  logic                  irq
);

   logic [vic_pkg::NSRC-1:0] req;
   logic [vic_pkg::NSRC-1:0] ena;
   logic [7:0]               cfg;
   logic [vic_pkg::NSTS-1:0] sts;
   logic [vic_pkg::NSTS-1:0] msk;
   logic                     reset_pend;
   logic                     brk_pend;
   logic [3:0]               last_prio;
   logic                     ext_pulse;
   logic                     txp_pulse;
   logic                     key_pulse;
   logic                     key_and;
   logic                     wr_go;
   logic                     rd_go;
   logic [15:0]              lane_mask;
   logic [vic_pkg::NSRC-1:0] ev;
   logic [vic_pkg::NSRC-1:0] sw_clr;
   logic [vic_pkg::NSRC-1:0] acc_clr;
   logic [vic_pkg::NSRC-1:0] live;
   logic [9:1]               slot_req;
   logic [3:0]               win;
   logic                     acc_go;
   logic [vic_pkg::NSTS-1:0] sts_ev;
   logic [31:0]              next_readdata;

   // register bus: one wait cycle, then the access completes
   assign wr_go     = ce && avs_write && !avs_waitrequest;
   assign rd_go     = ce && avs_read && !avs_waitrequest;
   assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
      end
      else if (ce)
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   always_comb
   begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address & 5'h1C)
         vic_pkg::OFF_REQ: next_readdata[vic_pkg::NSRC-1:0] = req;
         vic_pkg::OFF_ENA: next_readdata[vic_pkg::NSRC-1:0] = ena;
         vic_pkg::OFF_CFG: next_readdata[7:0] = cfg;
         vic_pkg::OFF_VEC: next_readdata[7:0] = {core_out.prio, last_prio};
         vic_pkg::OFF_STS: next_readdata[vic_pkg::NSTS-1:0] = sts;
         vic_pkg::OFF_MSK: next_readdata[vic_pkg::NSTS-1:0] = msk;
         default:          next_readdata = 32'h0000_0000;
      endcase
   end

   // data are captured in the wait cycle and stand at the completing edge
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (ce && avs_read && avs_waitrequest)
      begin
         avs_readdata <= next_readdata;
      end
   end

   // R11 selectable edge on the external pin
   vic_edge u_ext
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .level    (ext_irq_pin),
      .rise_sel (cfg[vic_pkg::CFG_EXT_RISE]),
      .pulse    (ext_pulse)
   );

   vic_edge u_txp
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .level    (timer_x_io_pin),
      .rise_sel (cfg[vic_pkg::CFG_TXP_RISE]),
      .pulse    (txp_pulse)
   );

   // R13 output pins read as high so they never trigger
   // R12 falling edge of the AND of the key inputs
   assign key_and = &(key_input_port | key_port_dir);

   vic_edge u_key
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .level    (key_and),
      .rise_sel (1'b0),
      .pulse    (key_pulse)
   );

   // R14 slot 2 and 3 sources follow the serial mode
   // R16 timer 1 underflow feeds slot 6
   always_comb
   begin
      ev = '0;
      ev[vic_pkg::SRC_S2]   = cfg[vic_pkg::CFG_USB] ? src.usb_in_tok : src.uart_rx_done;
      ev[vic_pkg::SRC_S3]   = cfg[vic_pkg::CFG_USB] ? src.usb_out_evt : src.uart_tx_done;
      ev[vic_pkg::SRC_EXT]  = ext_pulse;
      ev[vic_pkg::SRC_TMX]  = src.timer_x_uf;
      ev[vic_pkg::SRC_KEY]  = key_pulse;
      ev[vic_pkg::SRC_TM1]  = src.timer1_uf;
      ev[vic_pkg::SRC_TM2]  = src.timer2_uf;
      ev[vic_pkg::SRC_SIO2] = src.sio2_done;
      ev[vic_pkg::SRC_TXP]  = txp_pulse;
      ev[vic_pkg::SRC_ADC]  = src.adc_done;
   end

   // R5 shared slots see only the selected source
   // R15 slot 5, 7 and 8 pairings
   always_comb
   begin
      live = req & ena;
      live[vic_pkg::SRC_TMX]  = live[vic_pkg::SRC_TMX] && !cfg[vic_pkg::CFG_SEL5];
      live[vic_pkg::SRC_KEY]  = live[vic_pkg::SRC_KEY] && cfg[vic_pkg::CFG_SEL5];
      live[vic_pkg::SRC_TM2]  = live[vic_pkg::SRC_TM2] && !cfg[vic_pkg::CFG_SEL6];
      live[vic_pkg::SRC_SIO2] = live[vic_pkg::SRC_SIO2] && cfg[vic_pkg::CFG_SEL6];
      live[vic_pkg::SRC_TXP]  = live[vic_pkg::SRC_TXP] && !cfg[vic_pkg::CFG_SEL7];
      live[vic_pkg::SRC_ADC]  = live[vic_pkg::SRC_ADC] && cfg[vic_pkg::CFG_SEL7];
   end

   // R6 reset and break bypass the disable flag
   // R2 maskable slots need enable, request and a clear flag
   // R1 eleven sources folded into nine slots
   always_comb
   begin
      slot_req    = '0;
      slot_req[1] = reset_pend;
      slot_req[2] = live[vic_pkg::SRC_S2] && !core_in.disable_flag;
      slot_req[3] = live[vic_pkg::SRC_S3] && !core_in.disable_flag;
      slot_req[4] = live[vic_pkg::SRC_EXT] && !core_in.disable_flag;
      slot_req[5] = (live[vic_pkg::SRC_TMX] || live[vic_pkg::SRC_KEY]) && !core_in.disable_flag;
      slot_req[6] = live[vic_pkg::SRC_TM1] && !core_in.disable_flag;
      slot_req[7] = (live[vic_pkg::SRC_TM2] || live[vic_pkg::SRC_SIO2]) && !core_in.disable_flag;
      slot_req[8] = (live[vic_pkg::SRC_TXP] || live[vic_pkg::SRC_ADC]) && !core_in.disable_flag;
      slot_req[9] = brk_pend;
   end

   // R7 lowest slot number wins
   assign win    = vic_pkg::vic_pick(slot_req);
   assign acc_go = ce && core_in.accept && core_out.pending;

   // only the selected member of the presented slot is cleared
   always_comb
   begin
      acc_clr = '0;
      if (acc_go)
      begin
         unique case (core_out.prio)
            4'h2:    acc_clr[vic_pkg::SRC_S2]  = 1'b1;
            4'h3:    acc_clr[vic_pkg::SRC_S3]  = 1'b1;
            4'h4:    acc_clr[vic_pkg::SRC_EXT] = 1'b1;
            4'h5:    acc_clr = live & 10'h018;
            4'h6:    acc_clr[vic_pkg::SRC_TM1] = 1'b1;
            4'h7:    acc_clr = live & 10'h0C0;
            4'h8:    acc_clr = live & 10'h300;
            default: acc_clr = '0;
         endcase
      end
   end

   // R3 a written zero clears, a written one keeps
   assign sw_clr = (wr_go && (avs_address & 5'h1C) == vic_pkg::OFF_REQ) ?
                   (~avs_writedata[vic_pkg::NSRC-1:0] & lane_mask[vic_pkg::NSRC-1:0]) : '0;

   // R17 latched until cleared; a new event beats any clear
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         req <= vic_pkg::REQ_RST;
      end
      else if (ce)
      begin
         req <= (req & ~sw_clr & ~acc_clr) | ev;
      end
   end

   // R4 enable bits written per byte lane and read back whole
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ena <= vic_pkg::ENA_RST;
         cfg <= vic_pkg::CFG_RST;
         msk <= vic_pkg::MSK_RST;
      end
      else if (wr_go)
      begin
         if ((avs_address & 5'h1C) == vic_pkg::OFF_ENA)
         begin
            ena <= (ena & ~lane_mask[vic_pkg::NSRC-1:0])
                 | (avs_writedata[vic_pkg::NSRC-1:0] & lane_mask[vic_pkg::NSRC-1:0]);
         end
         if ((avs_address & 5'h1C) == vic_pkg::OFF_CFG && avs_byteenable[0])
         begin
            cfg <= avs_writedata[7:0];
         end
         if ((avs_address & 5'h1C) == vic_pkg::OFF_MSK && avs_byteenable[0])
         begin
            msk <= avs_writedata[vic_pkg::NSTS-1:0];
         end
      end
   end

   // reset is served as the first interrupt; break waits for acceptance
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         reset_pend <= 1'b1;
         brk_pend   <= 1'b0;
      end
      else if (ce)
      begin
         if (acc_go && core_out.prio == vic_pkg::PRIO_RESET)
         begin
            reset_pend <= 1'b0;
         end
         brk_pend <= core_in.break_exec
                  || (brk_pend && !(acc_go && core_out.prio == vic_pkg::PRIO_BRK));
      end
   end

   // R8 vector follows the winning slot
   // R9 acceptance pulses the disable-flag set
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         core_out  <= '0;
         last_prio <= vic_pkg::PRIO_NONE;
      end
      else if (ce)
      begin
         core_out.pending     <= (win != vic_pkg::PRIO_NONE) && !acc_go;
         core_out.prio        <= win;
         core_out.vector      <= vic_pkg::vic_vector(win);
         core_out.set_disable <= acc_go;
         if (acc_go)
         begin
            last_prio <= core_out.prio;
         end
      end
   end

   // sticky events; reading the status clears, a same-cycle event survives
   assign sts_ev = {core_in.break_exec, key_pulse, acc_go};

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sts <= vic_pkg::STS_RST;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         if (rd_go && (avs_address & 5'h1C) == vic_pkg::OFF_STS)
         begin
            sts <= sts_ev;
         end
         else
         begin
            sts <= sts | sts_ev;
         end
         irq <= |(sts & msk);
      end
   end

   property p_no_sw_set;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> (req & ~$past(req) & ~$past(ev)) == '0;
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) else $error("request bit set without event"); // R3

   property p_masked;
      @(posedge mclk) disable iff (!rst_n)
      (core_out.pending && core_out.prio > 4'h1 && core_out.prio < 4'h9)
         |-> !$past(core_in.disable_flag);
   endproperty
   a_masked: assert property (p_masked) else $error("maskable slot offered while disabled"); // R2

   property p_ena_rw;
      @(posedge mclk) disable iff (!rst_n)
      (wr_go && (avs_address & 5'h1C) == vic_pkg::OFF_ENA && avs_byteenable[1:0] == 2'h3)
         |=> ena == $past(avs_writedata[vic_pkg::NSRC-1:0]);
   endproperty
   a_ena_rw: assert property (p_ena_rw) else $error("enable write lost"); // R4

   property p_prio;
      @(posedge mclk) disable iff (!rst_n)
      ce |=> core_out.prio == vic_pkg::vic_pick($past(slot_req));
   endproperty
   a_prio: assert property (p_prio) else $error("wrong priority winner"); // R7

   property p_vector;
      @(posedge mclk) disable iff (!rst_n)
      core_out.pending |-> core_out.vector == 16'hFFFE - {11'h000, core_out.prio, 1'b0};
   endproperty
   a_vector: assert property (p_vector) else $error("vector does not match priority"); // R8

   property p_accept;
      @(posedge mclk) disable iff (!rst_n)
      acc_go |=> core_out.set_disable && !core_out.pending;
   endproperty
   a_accept: assert property (p_accept) else $error("acceptance not answered"); // R9

   property p_key;
      @(posedge mclk) disable iff (!rst_n)
      (ce && $past(ce) && $past(key_and) && !key_and) ##1 ce [*2]
         |=> req[vic_pkg::SRC_KEY];
   endproperty
   a_key: assert property (p_key) else $error("key fall not latched"); // R12

   property p_brk;
      @(posedge mclk) disable iff (!rst_n)
      (ce && core_in.break_exec && !reset_pend) ##1 ce |=> core_out.prio != vic_pkg::PRIO_NONE;
   endproperty
   a_brk: assert property (p_brk) else $error("break not offered"); // R6

   property p_hold;
      @(posedge mclk) disable iff (!rst_n)
      (req[vic_pkg::SRC_TM1] && sw_clr == '0 && !acc_go) |=> req[vic_pkg::SRC_TM1];
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped on its own"); // R17

   c_accept_maskable: cover property (@(posedge mclk) acc_go && core_out.prio == 4'h6);
   c_accept_break: cover property (@(posedge mclk) acc_go && core_out.prio == vic_pkg::PRIO_BRK);
   c_key_wake: cover property (@(posedge mclk) key_pulse ##[1:4] core_out.prio == 4'h5);
   c_irq: cover property (@(posedge mclk) irq);

endmodule
`default_nettype wire

// [vic_pkg.sv]
package vic_pkg;

   // register byte offsets
   localparam logic [4:0] OFF_REQ = 5'h00;
   localparam logic [4:0] OFF_ENA = 5'h04;
   localparam logic [4:0] OFF_CFG = 5'h08;
   localparam logic [4:0] OFF_VEC = 5'h0C;
   localparam logic [4:0] OFF_STS = 5'h10;
   localparam logic [4:0] OFF_MSK = 5'h14;

   // request and enable bit positions
   localparam int SRC_S2   = 0;
   localparam int SRC_S3   = 1;
   localparam int SRC_EXT  = 2;
   localparam int SRC_TMX  = 3;
   localparam int SRC_KEY  = 4;
   localparam int SRC_TM1  = 5;
   localparam int SRC_TM2  = 6;
   localparam int SRC_SIO2 = 7;
   localparam int SRC_TXP  = 8;
   localparam int SRC_ADC  = 9;
   localparam int NSRC     = 10;

   // configuration bit positions
   localparam int CFG_EXT_RISE = 0;
   localparam int CFG_TXP_RISE = 1;
   localparam int CFG_USB      = 2;
   localparam int CFG_SEL5     = 5;
   localparam int CFG_SEL6     = 6;
   localparam int CFG_SEL7     = 7;

   // event status bit positions
   localparam int STS_ACC = 0;
   localparam int STS_KEY = 1;
   localparam int STS_BRK = 2;
   localparam int NSTS    = 3;

   // reset values
   localparam logic [NSRC-1:0] REQ_RST = 10'h000;
   localparam logic [NSRC-1:0] ENA_RST = 10'h000;
   localparam logic [7:0]      CFG_RST = 8'h00;
   localparam logic [NSTS-1:0] STS_RST = 3'h0;
   localparam logic [NSTS-1:0] MSK_RST = 3'h0;

   // priorities and vectors
   localparam logic [3:0]  PRIO_NONE  = 4'h0;
   localparam logic [3:0]  PRIO_RESET = 4'h1;
   localparam logic [3:0]  PRIO_BRK   = 4'h9;
   localparam logic [15:0] VEC_TOP    = 16'hFFFC;

   typedef struct packed {
      logic uart_rx_done;
      logic uart_tx_done;
      logic usb_in_tok;
      logic usb_out_evt;
      logic timer_x_uf;
      logic timer1_uf;
      logic timer2_uf;
      logic sio2_done;
      logic adc_done;
   } vic_src_s;

   typedef struct packed {
      logic disable_flag;
      logic accept;
      logic break_exec;
   } vic_core_in_s;

   typedef struct packed {
      logic        pending;
      logic [3:0]  prio;
      logic [15:0] vector;
      logic        set_disable;
   } vic_core_out_s;

   // lowest set slot number wins; 0 when none
   function automatic logic [3:0] vic_pick(input logic [9:1] slot);
      logic [3:0] p;
      p = PRIO_NONE;
      for (int i = 9; i >= 1; i--)
      begin
         if (slot[i])
         begin
            p = 4'(i);
         end
      end
      return p;
   endfunction

   // low byte address of the vector pair for a slot
   function automatic logic [15:0] vic_vector(input logic [3:0] prio);
      return VEC_TOP - {11'h000, prio - 4'h1, 1'b0};
   endfunction

endpackage

// [vic_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module vic_edge
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic level,
   input  wire logic rise_sel,
   output var  logic pulse
);

   logic prev;
   logic primed;

   // primed blocks a false edge on the first sample after reset
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         prev   <= 1'b0;
         primed <= 1'b0;
         pulse  <= 1'b0;
      end
      else if (ce)
      begin
         prev   <= level;
         primed <= 1'b1;
         pulse  <= primed && (rise_sel ? (level && !prev) : (!level && prev));
      end
   end

endmodule
`default_nettype wire

// [vic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
(
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   go,
   input  wire logic [3:0]             lag,
   input  wire logic                   clr_flag,
   input  wire logic                   software_break_instr,
   input  wire vic_pkg::vic_core_out_s core_out,
   output var  vic_pkg::vic_core_in_s  core_in,
   output var  logic [3:0]             last_prio,
   output var  logic [15:0]            last_vec,
   output var  logic [7:0]             acc_count
);
   logic [3:0] wait_cnt;

   // lag lets the bench play a slow core that sits on a pending request
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         core_in   <= '0;
         wait_cnt  <= 4'h0;
         last_prio <= 4'h0;
         last_vec  <= 16'h0000;
         acc_count <= 8'h00;
      end
      else
      begin
         core_in.break_exec <= software_break_instr;
         core_in.accept     <= 1'b0;
         if (core_out.set_disable)
         begin
            core_in.disable_flag <= 1'b1;
         end
         else if (clr_flag)
         begin
            core_in.disable_flag <= 1'b0;
         end
         if (core_in.accept && core_out.pending)
         begin
            last_prio <= core_out.prio;
            last_vec  <= core_out.vector;
            acc_count <= acc_count + 8'h01;
            wait_cnt  <= 4'h0;
         end
         else if (go && core_out.pending && !core_in.accept)
         begin
            if (wait_cnt >= lag)
            begin
               core_in.accept <= 1'b1;
            end
            else
            begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [vectored_interrupt_controller_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_bench;
   logic                   mclk;
   logic                   rst_n;
   logic                   ce;
   logic [4:0]             avs_address;
   logic                   avs_read;
   logic                   avs_write;
   logic [31:0]            avs_writedata;
   logic [3:0]             avs_byteenable;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   vic_pkg::vic_src_s      src;
   logic                   ext_irq_pin;
   logic                   timer_x_io_pin;
   logic [7:0]             key_input_port;
   logic [7:0]             key_port_dir;
   vic_pkg::vic_core_in_s  core_in;
   vic_pkg::vic_core_out_s core_out;
   logic                   irq;
   logic                   go;
   logic [3:0]             lag;
   logic                   clr_flag;
   logic                   software_break_instr;
   logic [3:0]             last_prio;
   logic [15:0]            last_vec;
   logic [7:0]             acc_count;
   logic [31:0]            q;
   int                     fail_count;
   int                     checks;

   vic_top dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src(src), .ext_irq_pin(ext_irq_pin),
      .timer_x_io_pin(timer_x_io_pin), .key_input_port(key_input_port),
      .key_port_dir(key_port_dir), .core_in(core_in), .core_out(core_out), .irq(irq));

   vic_core_model core (.mclk(mclk), .rst_n(rst_n), .go(go), .lag(lag), .clr_flag(clr_flag),
      .software_break_instr(software_break_instr), .core_out(core_out), .core_in(core_in), .last_prio(last_prio),
      .last_vec(last_vec), .acc_count(acc_count));

   task automatic close_out();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            fail_count++;
            close_out();
         end
         @(posedge mclk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge mclk);
   endtask

   // field order msb first: rx, tx, usb in, usb out, timer x, timer1, timer2, sio2, adc
   task automatic pulse(input vic_pkg::vic_src_s s);
      src <= s;
      @(posedge mclk);
      src <= '0;
      cyc(3);
   endtask

   task automatic clr();
      clr_flag <= 1'b1;
      @(posedge mclk);
      clr_flag <= 1'b0;
   endtask

   task automatic wait_acc(input logic [7:0] n);
      int k;
      k = 0;
      while (acc_count !== n)
      begin
         k++;
         if (k > 300)
         begin
            fail_count++;
            close_out();
         end
         @(posedge mclk);
      end
      cyc(2);
   endtask

   task automatic t_reset();
      go <= 1'b1;
      wait_acc(8'h01);
      chk(32'(last_prio), 32'h1);
      chk(32'(last_vec), 32'hFFFC);
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, vic_pkg::OFF_VEC, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, vic_pkg::OFF_STS, 32'h0);
      chk(q, 32'h1);
   endtask

   task automatic t_regs();
      bus(1'b1, vic_pkg::OFF_ENA, 32'h3FF);
      bus(1'b0, vic_pkg::OFF_ENA, 32'h0);
      chk(q, 32'h3FF);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h0);
      bus(1'b0, vic_pkg::OFF_ENA, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, vic_pkg::OFF_REQ, 32'h3FF);
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 5'h18, 32'hFFFFFFFF);
      bus(1'b0, 5'h18, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, vic_pkg::OFF_VEC, 32'hFF);
      bus(1'b0, vic_pkg::OFF_VEC, 32'h0);
      chk(q, 32'h1);
   endtask

   task automatic t_gate();
      lag <= 4'h9;
      bus(1'b1, vic_pkg::OFF_MSK, 32'h0);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h020);
      pulse(9'h008);
      cyc(12);
      chk(32'(acc_count), 32'h1);
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h020);
      clr();
      wait_acc(8'h02);
      chk(32'(last_prio), 32'h6);
      chk(32'(last_vec), 32'hFFF2);
      chk(32'(core_in.disable_flag), 32'h1);
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h0);
      chk(32'(irq), 32'h0);
      bus(1'b1, vic_pkg::OFF_MSK, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h1);
      bus(1'b0, vic_pkg::OFF_STS, 32'h0);
      chk(q & 32'h1, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h0);
      lag <= 4'h2;
   endtask

   task automatic t_prio();
      bus(1'b1, vic_pkg::OFF_ENA, 32'h0);
      bus(1'b1, vic_pkg::OFF_CFG, 32'h01);
      bus(1'b1, vic_pkg::OFF_REQ, 32'h0);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h3FF);
      ext_irq_pin    <= 1'b1;
      timer_x_io_pin <= 1'b0;
      pulse(9'h19C);
      for (int p = 2; p <= 8; p++)
      begin
         clr();
         wait_acc(8'(p + 1));
         chk(32'(last_prio), 32'(p));
         chk(32'(last_vec), 32'hFFFC - 32'(2 * (p - 1)));
      end
      software_break_instr <= 1'b1;
      @(posedge mclk);
      software_break_instr <= 1'b0;
      wait_acc(8'h0A);
      chk(32'(last_prio), 32'h9);
      chk(32'(last_vec), 32'hFFEC);
   endtask

   task automatic t_key();
      go <= 1'b0;
      bus(1'b1, vic_pkg::OFF_ENA, 32'h0);
      bus(1'b1, vic_pkg::OFF_CFG, 32'h21);
      bus(1'b1, vic_pkg::OFF_REQ, 32'h0);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h018);
      clr();
      pulse(9'h010);
      chk(32'(core_out.pending), 32'h0);
      key_input_port <= 8'h7F;
      cyc(4);
      chk(32'(core_out.pending), 32'h0);
      key_input_port <= 8'h7E;
      cyc(4);
      chk(32'(core_out.prio), 32'h5);
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h018);
      bus(1'b1, vic_pkg::OFF_REQ, 32'h0);
      bus(1'b1, vic_pkg::OFF_CFG, 32'h05);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h001);
      pulse(9'h040);
      chk(32'(core_out.prio), 32'h2);
      bus(1'b1, vic_pkg::OFF_REQ, 32'h0);
      bus(1'b1, vic_pkg::OFF_CFG, 32'hC2);
      bus(1'b1, vic_pkg::OFF_ENA, 32'h3C0);
      // timer 2 is deselected, so it must not win slot 7 over slot 8
      pulse(9'h005);
      chk(32'(core_out.prio), 32'h8);
      pulse(9'h002);
      chk(32'(core_out.prio), 32'h7);
      // with the clock enable low a source pulse must be lost
      ce <= 1'b0;
      pulse(9'h008);
      ce <= 1'b1;
      bus(1'b0, vic_pkg::OFF_REQ, 32'h0);
      chk(q, 32'h2C0);
      bus(1'b0, vic_pkg::OFF_STS, 32'h0);
      chk(q, 32'h7);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial
   begin
      rst_n          = 1'b0;
      ce             = 1'b1;
      avs_address    = 5'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hF;
      src            = '0;
      ext_irq_pin    = 1'b0;
      timer_x_io_pin = 1'b1;
      key_input_port = 8'hFF;
      key_port_dir   = 8'hF0;
      go             = 1'b0;
      lag            = 4'h2;
      clr_flag       = 1'b0;
      software_break_instr            = 1'b0;
      fail_count     = 0;
      checks         = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_gate();
      t_prio();
      t_key();
      close_out();
   end
endmodule
`default_nettype wire
